// ==== rtl/spix_pkg.sv ====
// Constants shared by the serial port status and select control block.
// Assumes it is compiled ahead of every other file of the block.
package spix_pkg;

    // Slave-select mode field encodings
    localparam logic [1:0] SSM_THREE_WIRE = 2'h0;
    localparam logic [1:0] SSM_FOUR_WIRE  = 2'h1;
    localparam int         SSM_SINGLE_BIT = 1;     // Upper bit set: single master
    localparam int         SSM_LOW_BIT    = 0;     // Low bit drives pin in single master

    // Data widths and buffer shape
    localparam int         DATA_W         = 8;
    localparam int         TX_DEPTH       = 2;

    // Reset values
    localparam logic [7:0] DATA_RST       = 8'h00;
    localparam logic       FLAG_RST       = 1'b0;
    localparam logic       SYNC_RST       = 1'b1;  // Select pin idles high

    // Transmit buffer pointer width
    localparam int         PTR_W          = 1;

endpackage

// ==== rtl/spix_status_ctrl.sv ====
// Status flags, transmit/receive buffers and slave-select control of a serial port.
// Assumes a shift engine on the same clock signals loads and last-bit events.
`timescale 1ns/10ps
module spix_status_ctrl
(
    // Clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        resetn_in,
    // Core data port
    input  wire logic        data_wr_in,
    input  wire logic [7:0]  data_wdata_in,
    output logic             data_wr_ready_out,
    input  wire logic        data_rd_in,
    output logic [7:0]       serial_data_buffer_out,
    // Control bits
    input  wire logic        master_enable_bit_in,
    input  wire logic [1:0]  slave_select_mode_in,
    input  wire logic        int_enable_in,
    input  wire logic        mode_fault_clr_in,
    input  wire logic        receive_overrun_clr_in,
    // Status bits
    output logic             mode_fault_flag_out,
    output logic             receive_overrun_flag_out,
    output logic             transmit_buffer_empty_out,
    output logic             int_req_out,
    // Shift engine side
    output logic             xfer_start_out,
    output logic             tx_valid_out,
    output logic [7:0]       tx_data_out,
    input  wire logic        tx_load_in,
    input  wire logic        last_bit_in,
    input  wire logic [7:0]  rx_data_in,
    output logic             slave_selected_out,
    // Slave-select pin
    input  wire logic        slave_select_pin_in,
    output logic             slave_select_pin_out,
    output logic             slave_select_pin_oe_n_out
);

    logic       ss_meta_q;
    logic       ss_sync_q;
    logic       mode_fault_q;
    logic       overrun_q;
    logic       rx_full_q;
    logic [7:0] rx_buf_q;
    logic       start_q;
    logic       tx_empty;
    logic       four_wire;
    logic       single_master;
    logic       fault_event;
    logic       overrun_event;
    logic       wr_accept;

    spix_stream_if wr_if ();
    spix_stream_if tx_if ();

    // Select pin synchroniser
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            ss_meta_q <= spix_pkg::SYNC_RST;
            ss_sync_q <= spix_pkg::SYNC_RST;
        end
        else
        begin
            ss_meta_q <= slave_select_pin_in;
            ss_sync_q <= ss_meta_q;
        end
    end

    // Mode decode
    assign four_wire     = (slave_select_mode_in == spix_pkg::SSM_FOUR_WIRE);
    assign single_master = slave_select_mode_in[spix_pkg::SSM_SINGLE_BIT];

    // Select pin drive: only single master mode drives it
    assign slave_select_pin_out      = single_master
                                       ? slave_select_mode_in[spix_pkg::SSM_LOW_BIT]
                                       : 1'b1;
    assign slave_select_pin_oe_n_out = !single_master;

    // Slave is selected by a low pin in four-wire, always in three-wire
    assign slave_selected_out = four_wire ? !ss_sync_q
                                          : (slave_select_mode_in == spix_pkg::SSM_THREE_WIRE);

    // Detection terms
    assign fault_event   = !ss_sync_q && master_enable_bit_in && four_wire;
    assign overrun_event = last_bit_in && rx_full_q && !master_enable_bit_in;

    // Mode fault flag, set wins over clear
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            mode_fault_q <= spix_pkg::FLAG_RST;
        end
        else if (fault_event)
        begin
            mode_fault_q <= 1'b1;
        end
        else if (mode_fault_clr_in)
        begin
            mode_fault_q <= 1'b0;
        end
    end

    // Receive overrun flag, set wins over clear
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            overrun_q <= spix_pkg::FLAG_RST;
        end
        else if (overrun_event)
        begin
            overrun_q <= 1'b1;
        end
        else if (receive_overrun_clr_in)
        begin
            overrun_q <= 1'b0;
        end
    end

    // Receive buffer and its unread marker; a new byte wins over a same-cycle read
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rx_buf_q  <= spix_pkg::DATA_RST;
            rx_full_q <= spix_pkg::FLAG_RST;
        end
        else if (last_bit_in)
        begin
            rx_buf_q  <= rx_data_in;
            rx_full_q <= 1'b1;
        end
        else if (data_rd_in)
        begin
            rx_full_q <= 1'b0;
        end
    end

    // Read data returns receive buffer
    assign serial_data_buffer_out = rx_buf_q;

    // Core writes enter the transmit buffer
    assign wr_if.valid       = data_wr_in;
    assign wr_if.data        = data_wdata_in;
    assign data_wr_ready_out = wr_if.ready;
    assign wr_accept         = data_wr_in && wr_if.ready;

    // Transfer start pulse for master writes
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            start_q <= spix_pkg::FLAG_RST;
        end
        else
        begin
            start_q <= wr_accept && master_enable_bit_in;
        end
    end
    assign xfer_start_out = start_q;

    // Transmit buffer instance; shift engine load drains it
    spix_tx_buffer u_tx_buffer
    (
        .ref_clk_in (ref_clk_in),
        .resetn_in  (resetn_in),
        .fill       (wr_if.snk),
        .drain      (tx_if.src),
        .empty_out  (tx_empty)
    );

    assign tx_valid_out              = tx_if.valid;
    assign tx_data_out               = tx_if.data;
    assign tx_if.ready               = tx_load_in;
    assign transmit_buffer_empty_out = tx_empty;

    // Flags and interrupt request
    assign mode_fault_flag_out      = mode_fault_q;
    assign receive_overrun_flag_out = overrun_q;
    assign int_req_out = int_enable_in && (mode_fault_q || overrun_q);

    // Mode fault follows its cause and holds until cleared
    mode_fault_set_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        fault_event |=> mode_fault_flag_out)
        else $error("mode fault not set by select low in master four-wire");

    mode_fault_hold_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        mode_fault_flag_out && !mode_fault_clr_in |=> mode_fault_flag_out)
        else $error("mode fault dropped without clear");

    overrun_set_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        last_bit_in && rx_full_q && !master_enable_bit_in
        |=> receive_overrun_flag_out)
        else $error("overrun not set on unread receive buffer");

    overrun_master_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        !receive_overrun_flag_out && master_enable_bit_in
        |=> !receive_overrun_flag_out)
        else $error("overrun set while master");

    select_drive_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        slave_select_mode_in[1] |-> !slave_select_pin_oe_n_out
        && slave_select_pin_out == slave_select_mode_in[0])
        else $error("select pin drive wrong for single master");

    tx_empty_clear_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        wr_accept && !tx_load_in |=> !transmit_buffer_empty_out)
        else $error("transmit empty not cleared by write");

    tx_empty_set_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        tx_valid_out && tx_load_in && !wr_accept
        && data_wr_ready_out |=> transmit_buffer_empty_out)
        else $error("transmit empty not set after load");

    master_start_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        wr_accept && master_enable_bit_in |=> xfer_start_out
        ##1 (!xfer_start_out || $past(wr_accept && master_enable_bit_in)))
        else $error("master write did not start transfer");

    read_data_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        last_bit_in |=> serial_data_buffer_out == $past(rx_data_in))
        else $error("read data not the received byte");

    int_level_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        int_req_out == (int_enable_in
        && (mode_fault_flag_out || receive_overrun_flag_out)))
        else $error("interrupt request does not follow flags");

endmodule

// ==== rtl/spix_stream_if.sv ====
// Valid/ready byte stream into the transmit buffer from the core write port and out of it to the shift engine.
// Assumes source and sink share one clock.
`timescale 1ns/10ps
interface spix_stream_if;
    logic                          valid;
    logic                          ready;
    logic [spix_pkg::DATA_W-1:0]   data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ==== rtl/spix_tx_buffer.sv ====
// Two-entry transmit buffer with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/10ps
module spix_tx_buffer
(
    // Clock and reset
    input  wire logic   ref_clk_in,
    input  wire logic   resetn_in,
    // Filling side
    spix_stream_if.snk  fill,
    // Draining side
    spix_stream_if.src  drain,
    // Status
    output logic        empty_out
);

    logic [spix_pkg::DATA_W-1:0] mem_q [spix_pkg::TX_DEPTH];
    logic [spix_pkg::PTR_W-1:0]  wr_ptr_q;
    logic [spix_pkg::PTR_W-1:0]  rd_ptr_q;
    logic [spix_pkg::PTR_W:0]    count_q;
    logic                        push;
    logic                        pop;

    // Honest full and empty from the occupancy count
    assign fill.ready  = (count_q != 2'(spix_pkg::TX_DEPTH));
    assign drain.valid = (count_q != 2'h0);
    assign drain.data  = mem_q[rd_ptr_q];
    assign empty_out   = (count_q == 2'h0);
    assign push        = fill.valid && fill.ready;
    assign pop         = drain.valid && drain.ready;

    // Storage write
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            mem_q[0] <= spix_pkg::DATA_RST;
            mem_q[1] <= spix_pkg::DATA_RST;
        end
        else if (push)
        begin
            mem_q[wr_ptr_q] <= fill.data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            wr_ptr_q <= 1'h0;
            rd_ptr_q <= 1'h0;
            count_q  <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= wr_ptr_q + 1'h1;
            end
            if (pop)
            begin
                rd_ptr_q <= rd_ptr_q + 1'h1;
            end
            if (push && !pop)
            begin
                count_q <= count_q + 2'h1;
            end
            else if (pop && !push)
            begin
                count_q <= count_q - 2'h1;
            end
        end
    end

    // Occupancy never passes the depth
    count_bound_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        count_q <= 2'(spix_pkg::TX_DEPTH))
        else $error("transmit buffer count above depth");

endmodule

// ==== tb/spix_far_model.sv ====
// Stand-in for the shift engine and far device: pops bytes, echoes them inverted.
// Assumes it shares clock and reset with the status block.
`timescale 1ns/10ps
module spix_far_model
(
    // Clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       resetn_in,
    // Bench control
    input  wire logic       stall_in,
    // Status block side
    input  wire logic       tx_valid_in,
    input  wire logic [7:0] tx_data_in,
    output logic            tx_load_out,
    output logic            last_bit_out,
    output logic [7:0]      rx_data_out
);
    // One pop every other cycle; received byte follows the pop by one cycle
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            tx_load_out  <= 1'b0;
            last_bit_out <= 1'b0;
            rx_data_out  <= 8'h00;
        end
        else
        begin
            tx_load_out  <= !tx_load_out && tx_valid_in && !stall_in;
            last_bit_out <= tx_load_out && tx_valid_in;
            // Outside a frame the data lines keep toggling
            rx_data_out  <= (tx_load_out && tx_valid_in) ? ~tx_data_in : ~rx_data_out;
        end
    end
endmodule

// ==== tb/spix_status_ctrl_tb.sv ====
// Self-checking bench for the status and select control block.
// Assumes the far model stands in for the shift engine.
`timescale 1ns/10ps
module spix_status_ctrl_tb;
    logic clk, rst_n, wr, rd, men, ien, mf_clr, ro_clr, stall, ss_drv;
    logic [7:0] wdat, rdat, txd, rxd;
    logic [1:0] ssm;
    logic rdy, mf, ro, emp, irq, start, txv, load, lastb, sel, ss_out, ss_oe_n, ss_pin;
    int num_errors, cmp_count;

    // Wire level of the select pin from both parties
    assign ss_pin = ss_oe_n ? ss_drv : ss_out;

    spix_status_ctrl i_spix_status_ctrl (.ref_clk_in(clk), .resetn_in(rst_n),
        .data_wr_in(wr), .data_wdata_in(wdat), .data_wr_ready_out(rdy), .data_rd_in(rd),
        .serial_data_buffer_out(rdat), .master_enable_bit_in(men),
        .slave_select_mode_in(ssm), .int_enable_in(ien), .mode_fault_clr_in(mf_clr),
        .receive_overrun_clr_in(ro_clr), .mode_fault_flag_out(mf),
        .receive_overrun_flag_out(ro), .transmit_buffer_empty_out(emp),
        .int_req_out(irq), .xfer_start_out(start), .tx_valid_out(txv),
        .tx_data_out(txd), .tx_load_in(load), .last_bit_in(lastb), .rx_data_in(rxd),
        .slave_selected_out(sel), .slave_select_pin_in(ss_pin),
        .slave_select_pin_out(ss_out), .slave_select_pin_oe_n_out(ss_oe_n));

    spix_far_model i_spix_far_model (.ref_clk_in(clk), .resetn_in(rst_n), .stall_in(stall),
        .tx_valid_in(txv), .tx_data_in(txd), .tx_load_out(load), .last_bit_out(lastb),
        .rx_data_out(rxd));

    // Clock of 8 ns
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Compare one value
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Step past edges, landing just after the last one
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One write per cycle; the strobe stays up between bytes of a burst
    task automatic wr_byte(input logic [7:0] b, input logic last);
        wr = 1'b1;
        wdat = b;
        cyc(1);
        if (last)
            wr = 1'b0;
    endtask

    // Bounded wait for the transmit buffer to drain, then let the echo land
    task automatic wait_empty();
        int i;
        for (i = 0; i < 40 && emp !== 1'b1; i++)
            cyc(1);
        if (emp !== 1'b1)
        begin
            num_errors++;
            $display("ERROR wait_empty expected 1 seen %b", emp);
            test_done();
        end
        cyc(3);
    endtask

    // Values while reset is still held low
    task automatic t_reset();
        chk("empty", emp, 1'b1);
        chk("ready", rdy, 1'b1);
        chk("flags", {mf, ro, txv, start}, 4'h0);
        chk("rx data", rdat, 8'h00);
        $display("test reset done");
    endtask

    // Master fill past capacity with far side stalled, then drain
    task automatic t_fill();
        men = 1'b1;
        stall = 1'b1;
        wr_byte(8'h3c, 1'b0);
        chk("empty", emp, 1'b0);
        chk("start", start, 1'b1);
        wr_byte(8'ha5, 1'b0);
        chk("ready", rdy, 1'b0);
        chk("head", txd, 8'h3c);
        wr_byte(8'h77, 1'b1);
        stall = 1'b0;
        wait_empty();
        chk("rx data", rdat, 8'h5a);
        chk("overrun", ro, 1'b0);
        $display("test fill done");
    endtask

    // Slave receive twice unread, interrupt, clear
    task automatic t_overrun();
        men = 1'b0;
        ien = 1'b1;
        rd = 1'b1;
        cyc(1);
        rd = 1'b0;
        wr_byte(8'h01, 1'b0);
        chk("start", start, 1'b0);
        wr_byte(8'h02, 1'b1);
        wait_empty();
        chk("overrun", ro, 1'b1);
        chk("irq", irq, 1'b1);
        ro_clr = 1'b1;
        cyc(1);
        ro_clr = 1'b0;
        chk("overrun", ro, 1'b0);
        chk("irq", irq, 1'b0);
        $display("test overrun done");
    endtask

    // Mode fault: set, sticky, masked, cleared; no fault in mode 00
    task automatic t_fault();
        men = 1'b1;
        ssm = 2'h0;
        ss_drv = 1'b0;
        cyc(4);
        chk("fault", mf, 1'b0);
        ssm = 2'h1;
        cyc(4);
        chk("fault", mf, 1'b1);
        ss_drv = 1'b1;
        cyc(4);
        chk("fault", mf, 1'b1);
        chk("irq", irq, 1'b1);
        ien = 1'b0;
        cyc(1);
        chk("irq", irq, 1'b0);
        chk("fault", mf, 1'b1);
        mf_clr = 1'b1;
        cyc(1);
        mf_clr = 1'b0;
        chk("fault", mf, 1'b0);
        $display("test fault done");
    endtask

    // Select pin behaviour for every mode
    task automatic t_modes();
        int m;
        men = 1'b0;
        ss_drv = 1'b0;
        for (m = 0; m < 4; m++)
        begin
            ssm = m[1:0];
            cyc(3);
            chk("oe_n", ss_oe_n, m < 2);
            chk("selected", sel, m < 2);
            if (m >= 2)
                chk("pin", ss_out, m[0]);
        end
        $display("test modes done");
    endtask

    // Main sequence
    initial
    begin
        num_errors = 0;
        cmp_count = 0;
        {wr, rd, men, ien, mf_clr, ro_clr, stall} = 7'h00;
        rst_n = 1'b0;
        ss_drv = 1'b1;
        wdat = 8'h00;
        ssm = 2'h1;
        repeat (8) @(posedge clk);
        #1;
        t_reset();
        rst_n = 1'b1;
        cyc(3);
        t_fill();
        t_overrun();
        t_fault();
        t_modes();
        test_done();
    end
endmodule
